// ---- hw/cdc_config.sv ----
// How it works
// - selector picks sensor or temperature path
// - single sensor and differential ratio modes
// - nonvolatile config word latched per conversion
// - reference from trim field and range code
// - offset equals multiplier times trim times 1pF
// - single ended: (c0 - offset) over reference
// - raw value is ratio times two^resolution
// - zero reference trim divides by external c1
// - differential: c0 over c0 plus c1
// - range code sets frequency and total multiplier
// - larger multiplier lengthens conversion time
// - far overrange input may look valid
// - temperature reading delivered fourteen bits wide
// - excitation frequency divided by multiplier
`timescale 1ns/1ps
`include "cdc_consts.svh"
module cdc_config
    import cdc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire cdc_cfg_t nvm_cfg,
    input wire cdc_caps_t caps_in,
    input wire logic [13:0] temp_in,
    input wire logic conv_start,
    output logic busy,
    output logic done,
    output logic [13:0] result,
    output logic clamped,
    output logic exc_out
);

    // frequency multiplier 1, 2, 4, 8
    function automatic logic [3:0] freq_mult(input logic [1:0] code);
        freq_mult = 4'(4'h1 << code);
    endfunction

    // total capacitance multiplier in hundredths
    function automatic logic [13:0] cmult(input logic [1:0] code);
        case (code)
            2'h0: cmult = `CDC_CMULT_0;
            2'h1: cmult = `CDC_CMULT_1;
            2'h2: cmult = `CDC_CMULT_2;
            default: cmult = `CDC_CMULT_3;
        endcase
    endfunction

    localparam logic [15:0] SETTLE_CYC = 16'(`CDC_SETTLE_CYC);
    localparam logic [15:0] EXC_HALF_CYC = 16'(`CDC_EXC_HALF_CYC);

    cdc_state_t state_reg;
    cdc_cfg_t cfg_reg;
    cdc_caps_t caps_reg;
    logic [13:0] temp_reg;
    logic [15:0] wait_reg;
    logic [3:0] bit_reg;
    logic [17:0] rem_reg;
    logic [13:0] quo_reg;
    logic [15:0] exc_cnt_reg;
    logic [16:0] coff;
    logic [16:0] cref;
    logic [16:0] num;
    logic [16:0] den;
    logic below_zero;
    logic at_one;
    logic [17:0] rem_sh;
    logic [13:0] full_code;
    logic [13:0] scaled;
    logic [13:0] quo_next;

    // offset and reference capacitors from trims
    assign coff = 17'(cmult(cfg_reg.range_multiplier_code))
                * 17'(cfg_reg.offset_trim_field);
    assign cref = 17'(cmult(cfg_reg.range_multiplier_code))
                * 17'(cfg_reg.reference_trim_field);

    // numerator and denominator of the sensor ratio
    always_comb begin
        if (cfg_reg.diff_mode) begin
            num = {1'b0, caps_reg.c0};
            den = 17'({1'b0, caps_reg.c0}) + 17'({1'b0, caps_reg.c1});
        end else if (cfg_reg.reference_trim_field == 3'h0) begin
            num = 17'({1'b0, caps_reg.c0} - coff);
            den = {1'b0, caps_reg.c1};
        end else begin
            num = 17'({1'b0, caps_reg.c0} - coff);
            den = cref;
        end
    end

    // out-of-window ratios; far overrange is not detected here
    assign below_zero = !cfg_reg.diff_mode && ({1'b0, caps_reg.c0} < coff);
    assign at_one = !below_zero && (num >= den);

    // largest code at the selected resolution
    always_comb begin
        case (cfg_reg.result_resolution)
            `CDC_RES_8: full_code = 14'h00FF;
            `CDC_RES_10: full_code = 14'h03FF;
            `CDC_RES_12: full_code = 14'h0FFF;
            default: full_code = 14'h3FFF;
        endcase
    end

    // quotient including this cycle's bit, so the last bit is not lost
    assign quo_next = {quo_reg[12:0], rem_sh >= {1'b0, den}};

    // fraction scaled down to the selected resolution
    assign scaled = quo_next >> (4'(`CDC_FRAC_BITS)
                  - {1'b0, cfg_reg.result_resolution, 1'b0}
                  - 4'h8);
    assign rem_sh = {rem_reg[16:0], 1'b0};

    // conversion sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= CDC_IDLE;
            wait_reg <= 16'h0000;
            bit_reg <= 4'h0;
        end else begin
            case (state_reg)
                CDC_IDLE: begin
                    if (conv_start) begin
                        state_reg <= CDC_SETTLE;
                        wait_reg <= 16'(SETTLE_CYC
                            * freq_mult(nvm_cfg.range_multiplier_code)
                            - 16'h0001);
                    end
                end
                CDC_SETTLE: begin
                    if (wait_reg != 16'h0000) begin
                        wait_reg <= wait_reg - 16'h0001;
                    end else if (cfg_reg.temp_select || below_zero
                                 || at_one) begin
                        state_reg <= CDC_IDLE;
                    end else begin
                        state_reg <= CDC_DIVIDE;
                        bit_reg <= 4'(`CDC_FRAC_BITS - 1);
                    end
                end
                CDC_DIVIDE: begin
                    if (bit_reg == 4'h0) begin
                        state_reg <= CDC_IDLE;
                    end else begin
                        bit_reg <= bit_reg - 4'h1;
                    end
                end
                default: state_reg <= CDC_IDLE;
            endcase
        end
    end

    // configuration and inputs captured at conversion start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg <= '0;
            caps_reg <= '0;
            temp_reg <= 14'h0000;
        end else if (state_reg == CDC_IDLE && conv_start) begin
            cfg_reg <= nvm_cfg;
            caps_reg <= caps_in;
            temp_reg <= temp_in;
        end
    end

    // restoring division, one quotient bit per cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rem_reg <= 18'h00000;
            quo_reg <= 14'h0000;
        end else if (state_reg == CDC_SETTLE) begin
            rem_reg <= {1'b0, num};
            quo_reg <= 14'h0000;
        end else if (state_reg == CDC_DIVIDE) begin
            if (rem_sh >= {1'b0, den}) begin
                rem_reg <= rem_sh - {1'b0, den};
                quo_reg <= {quo_reg[12:0], 1'b1};
            end else begin
                rem_reg <= rem_sh;
                quo_reg <= {quo_reg[12:0], 1'b0};
            end
        end
    end

    // result selection and completion pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result <= `CDC_RESULT_RST;
            clamped <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (state_reg == CDC_SETTLE && wait_reg == 16'h0000) begin
                if (cfg_reg.temp_select) begin
                    result <= temp_reg;
                    clamped <= 1'b0;
                    done <= 1'b1;
                end else if (below_zero) begin
                    result <= 14'h0000;
                    clamped <= 1'b1;
                    done <= 1'b1;
                end else if (at_one) begin
                    result <= full_code;
                    clamped <= 1'b1;
                    done <= 1'b1;
                end
            end else if (state_reg == CDC_DIVIDE && bit_reg == 4'h0) begin
                result <= scaled;
                clamped <= 1'b0;
                done <= 1'b1;
            end
        end
    end

    // busy flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
        end else if (state_reg == CDC_IDLE) begin
            busy <= conv_start;
        end else begin
            busy <= !((state_reg == CDC_DIVIDE && bit_reg == 4'h0)
                || (state_reg == CDC_SETTLE && wait_reg == 16'h0000
                    && (cfg_reg.temp_select || below_zero || at_one)));
        end
    end

    // excitation square wave, slowed by the frequency multiplier
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            exc_cnt_reg <= 16'h0000;
            exc_out <= 1'b0;
        end else if (state_reg == CDC_IDLE) begin
            exc_cnt_reg <= 16'h0000;
            exc_out <= 1'b0;
        end else if (exc_cnt_reg == 16'(EXC_HALF_CYC
                     * freq_mult(cfg_reg.range_multiplier_code)
                     - 16'h0001)) begin
            exc_cnt_reg <= 16'h0000;
            exc_out <= !exc_out;
        end else begin
            exc_cnt_reg <= exc_cnt_reg + 16'h0001;
        end
    end

endmodule

// ---- shared/cdc_consts.svh ----
`ifndef CDC_CONSTS_SVH
`define CDC_CONSTS_SVH

// clock period of the block clock, ns
`define CDC_CLK_NS 20
// settle time of one conversion at frequency multiplier 1, ns
`define CDC_SETTLE_NS 2000
// settle cycles at multiplier 1, least time so rounded up
`define CDC_SETTLE_CYC ((`CDC_SETTLE_NS + `CDC_CLK_NS - 1) / `CDC_CLK_NS)
// excitation half period at multiplier 1, ns
`define CDC_EXC_HALF_NS 200
`define CDC_EXC_HALF_CYC ((`CDC_EXC_HALF_NS + `CDC_CLK_NS - 1) / `CDC_CLK_NS)

// total capacitance multiplier in hundredths
`define CDC_CMULT_0 14'd144
`define CDC_CMULT_1 14'd576
`define CDC_CMULT_2 14'd2304
`define CDC_CMULT_3 14'd9216

// resolution codes
`define CDC_RES_8 2'h0
`define CDC_RES_10 2'h1
`define CDC_RES_12 2'h2
`define CDC_RES_14 2'h3

// full internal fraction width of the divider
`define CDC_FRAC_BITS 14
`define CDC_RESULT_RST 14'h0000

`endif

// ---- shared/cdc_pkg.sv ----
package cdc_pkg;

    // configuration word as held in nonvolatile memory
    typedef struct packed {
        logic temp_select;
        logic diff_mode;
        logic [1:0] result_resolution;
        logic [1:0] range_multiplier_code;
        logic [2:0] reference_trim_field;
        logic [2:0] offset_trim_field;
    } cdc_cfg_t;

    // capacitances in hundredths of a picofarad
    typedef struct packed {
        logic [15:0] c0;
        logic [15:0] c1;
    } cdc_caps_t;

    typedef enum logic [2:0] {
        CDC_IDLE = 3'b001,
        CDC_SETTLE = 3'b010,
        CDC_DIVIDE = 3'b100
    } cdc_state_t;

endpackage

// ---- tb/cdc_config_sva.sv ----
`timescale 1ns/1ps
module cdc_config_sva
    import cdc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire cdc_cfg_t nvm_cfg,
    input wire cdc_caps_t caps_in,
    input wire logic [13:0] temp_in,
    input wire logic conv_start,
    input wire logic busy,
    input wire logic done,
    input wire logic [13:0] result,
    input wire logic clamped,
    input wire logic exc_out
);
    logic [9:0] busy_cnt_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // counts cycles spent busy, cleared when idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt_reg <= 10'h000;
        end else begin
            busy_cnt_reg <= busy ? busy_cnt_reg + 10'h001 : 10'h000;
        end
    end
    start_taken_a: assert property (
        conv_start && !busy && !done |=> busy)
        else $error("start not taken");
    done_pulse_a: assert property (done |=> !done)
        else $error("done longer than one cycle");
    done_ends_a: assert property (done |-> !busy && $past(busy))
        else $error("done without conversion");
    result_hold_a: assert property (!done |-> $stable(result))
        else $error("result changed without done");
    clamp_hold_a: assert property (!done |-> $stable(clamped))
        else $error("clamped changed without done");
    settle_min_a: assert property (done |-> busy_cnt_reg >= 10'h060)
        else $error("conversion too short");
    conv_bound_a: assert property ($rose(busy) |-> ##[99:816] done)
        else $error("conversion too long");
    exc_idle_a: assert property ((!busy)[*3] |-> !exc_out)
        else $error("excitation running while idle");
    clamp_code_a: assert property (
        done && clamped |-> result == 14'h0000 || result == 14'h00FF
        || result == 14'h03FF || result == 14'h0FFF || result == 14'h3FFF)
        else $error("clamp code not full or zero");
endmodule
bind cdc_config cdc_config_sva u_sva(.clk(clk), .rst_n(rst_n),
    .nvm_cfg(nvm_cfg), .caps_in(caps_in), .temp_in(temp_in),
    .conv_start(conv_start), .busy(busy), .done(done), .result(result),
    .clamped(clamped), .exc_out(exc_out));

// ---- tb/cdc_sensor_model.sv ----
`timescale 1ns/1ps
module cdc_sensor_model
    import cdc_pkg::*;
(
    input wire logic [15:0] c0_val,
    input wire logic [15:0] c1_val,
    output cdc_caps_t caps
);
    // sensor element c0 and its reference or twin c1, 0.01 pF units
    assign caps = '{c0: c0_val, c1: c1_val};
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`include "cdc_consts.svh"
module tb;
    import cdc_pkg::*;
    logic clk, rst_n, conv_start, busy, done, clamped, exc_out;
    cdc_cfg_t cfg;
    cdc_caps_t caps;
    logic [15:0] c0, c1;
    logic [13:0] result, tv;
    int n_mismatch = 0, compares = 0, cyc = 0;
    cdc_sensor_model u_sen(.c0_val(c0), .c1_val(c1), .caps(caps));
    cdc_config u_dut(.clk(clk), .rst_n(rst_n), .nvm_cfg(cfg),
        .caps_in(caps), .temp_in(tv), .conv_start(conv_start),
        .busy(busy), .done(done), .result(result), .clamped(clamped),
        .exc_out(exc_out));
    // clock and run limit
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // one conversion; config flipped and a stray start given mid-run
    task automatic run(input cdc_cfg_t f, input logic [15:0] a, b,
            input logic [13:0] er, input logic ec, input int en);
        int k;
        int fe;
        int fx;
        logic tog;
        @(negedge clk);
        cfg = f;
        c0 = a;
        c1 = b;
        conv_start = 1'b1;
        @(negedge clk);
        cfg = ~f;
        k = 1;
        tog = 1'b0;
        fe = 0;
        fx = (`CDC_EXC_HALF_CYC << f.range_multiplier_code) + 1;
        while (done !== 1'b1 && k < 2000) begin
            tog = tog | (exc_out === 1'b1);
            if (exc_out === 1'b1 && fe == 0) begin
                fe = k;
            end
            conv_start = (k == 50);
            @(negedge clk);
            k++;
        end
        check(k, en);
        check(result, er);
        check(clamped, ec);
        check(tog, 1'b1);
        check(fe, fx);
        repeat (2) @(negedge clk);
        check(busy, 1'b0);
        check(exc_out, 1'b0);
        $display("test done at %0t", $time);
    endtask
    // ranges 0..3 and resolutions 14,12,10,8 across the scenarios
    task t_single();
        run('{1'b0, 1'b0, 2'h3, 2'h0, 3'h7, 3'h1}, 16'h0258, 16'h0000,
            14'h1CF3, 1'b0, 115);
    endtask
    task t_extref();
        run('{1'b0, 1'b0, 2'h2, 2'h1, 3'h0, 3'h1}, 16'h0628, 16'h07D0,
            14'h0800, 1'b0, 215);
    endtask
    task t_diff();
        run('{1'b0, 1'b1, 2'h1, 2'h2, 3'h0, 3'h0}, 16'h0BB8, 16'h2328,
            14'h0100, 1'b0, 415);
    endtask
    task t_clamp_hi();
        run('{1'b0, 1'b0, 2'h0, 2'h0, 3'h1, 3'h0}, 16'h0090, 16'h0000,
            14'h00FF, 1'b1, 101);
    endtask
    task t_clamp_lo();
        run('{1'b0, 1'b0, 2'h0, 2'h0, 3'h1, 3'h3}, 16'h0064, 16'h0000,
            14'h0000, 1'b1, 101);
    endtask
    task t_temp();
        tv = 14'h2A5C;
        run('{1'b1, 1'b0, 2'h3, 2'h3, 3'h0, 3'h0}, 16'h0000, 16'h0000,
            14'h2A5C, 1'b0, 801);
    endtask
    // reset in mid-conversion clears every output
    task t_reset();
        @(negedge clk);
        cfg = '{1'b0, 1'b0, 2'h3, 2'h0, 3'h7, 3'h1};
        c0 = 16'h0258;
        conv_start = 1'b1;
        @(negedge clk);
        conv_start = 1'b0;
        repeat (30) @(negedge clk);
        check(busy, 1'b1);
        rst_n = 1'b0;
        @(negedge clk);
        check(busy, 1'b0);
        check(done, 1'b0);
        check(result, 14'h0000);
        check(clamped, 1'b0);
        check(exc_out, 1'b0);
        rst_n = 1'b1;
        $display("test done at %0t", $time);
    endtask
    task test_done();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        conv_start = 1'b0;
        cfg = '0;
        c0 = 16'h0000;
        c1 = 16'h0000;
        tv = 14'h0000;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        t_single();
        t_extref();
        t_diff();
        t_clamp_hi();
        t_clamp_lo();
        t_temp();
        t_reset();
        t_single();
        test_done();
    end
endmodule
